// file: verilog/adcsq_map.vh
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH
// Register byte offsets
`define ADCSQ_OFS_PRI 10'h020
`define ADCSQ_OFS_INIT 10'h028
`define ADCSQ_OFS_AVG 10'h030
`define ADCSQ_OFS_ACT 10'h000
`define ADCSQ_OFS_TRIG 10'h014
`define ADCSQ_OFS_STAT 10'h03C
`define ADCSQ_ADDR_W 10
// Priority field positions
`define ADCSQ_PRI_S0 0
`define ADCSQ_PRI_S1 4
`define ADCSQ_PRI_S2 8
`define ADCSQ_PRI_S3 12
`define ADCSQ_PRI_RST 8'hE4
// Averaging field
`define ADCSQ_AVG_LSB 0
`define ADCSQ_AVG_MSB 2
`define ADCSQ_AVG_RST 3'h0
// Trigger source: processor
`define ADCSQ_TRIG_CPU 4'h0
`define ADCSQ_TRIG_W 4
`define ADCSQ_DATA_W 10
`define ADCSQ_ACC_W 16
`define ADCSQ_NSEQ 4
`endif

// file: verilog/adcsq_arbiter.v
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_arbiter (
	// Pending and priority codes
	input wire [3:0] pend,
	input wire [7:0] codes,
	// Winner
	output reg [3:0] grant
);
	integer i;
	integer lvl;
	always @* begin
		grant = 4'h0;
		for (lvl = 3; lvl >= 0; lvl = lvl - 1) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (pend[i] && codes[2*i +: 2] == lvl[1:0]) begin
					grant = 4'h0;
					grant[i] = 1'b1;
				end
			end
		end
	end
endmodule

// file: verilog/adcsq_averager.v
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_averager (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Control
	input wire [2:0] avg_exp,
	input wire start,
	// Conversion in
	input wire conv_valid,
	input wire [`ADCSQ_DATA_W-1:0] conv_data,
	// Result out
	output reg res_valid_ff,
	output reg [`ADCSQ_DATA_W-1:0] res_data_ff
);
	reg [`ADCSQ_ACC_W-1:0] acc_ff;
	reg [6:0] cnt_ff;
	wire [6:0] need = 7'h01 << avg_exp;
	wire [`ADCSQ_ACC_W-1:0] sum = acc_ff + {6'h00, conv_data};
	wire [`ADCSQ_ACC_W-1:0] shifted = sum >> avg_exp;
	always @(posedge clk) begin
		if (reset || start) begin
			acc_ff <= 16'h0000;
			cnt_ff <= 7'h00;
			res_valid_ff <= 1'b0;
			res_data_ff <= 10'h000;
		end else begin
			res_valid_ff <= 1'b0;
			if (conv_valid) begin
				if (cnt_ff + 7'h01 == need) begin
					// Zero exponent passes straight through
					res_data_ff <= shifted[`ADCSQ_DATA_W-1:0];
					res_valid_ff <= 1'b1;
					acc_ff <= 16'h0000;
					cnt_ff <= 7'h00;
				end else begin
					acc_ff <= sum;
					cnt_ff <= cnt_ff + 7'h01;
				end
			end
		end
	end
endmodule

// file: verilog/adcsq_top.v
// How it works
// - Priority code 0 is most urgent, code 3 least urgent.
// - Reset priority codes are 0,1,2,3 for sequencers 0 to 3.
// - Priority fields sit at 13:12, 9:8, 5:4, 1:0; others read zero.
// - Writing one to initiate bit n triggers sequencer n.
// - Software trigger only starts a sequencer that is enabled.
// - Initiate register is write-only; reads return zero.
// - One write may initiate any subset of sequencers.
// - Simultaneous triggers run in priority order, most urgent first.
// - Each result averages two to the exponent conversions; field at 2:0.
// - Exponent zero passes conversions through unaveraged.
// - Exponent six averages 64 conversions per result.
// - Averaging control resets to zero.
// - Software initiation applies to sequencers whose trigger source is processor.
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_top (
	// Clock and reset
	input clk,
	input reset,
	// Avalon-MM slave
	input [`ADCSQ_ADDR_W-1:0] address,
	input read,
	input write,
	input [31:0] writedata,
	output reg [31:0] readdata_ff,
	output reg waitrequest_ff,
	// Hardware triggers, one per sequencer, from other clock or pins
	input [3:0] hw_trig,
	// Converter
	input conv_done,
	input [`ADCSQ_DATA_W-1:0] conv_data,
	output reg conv_start_ff,
	output reg [3:0] active_seq_ff,
	output reg conv_busy_ff,
	// Averaged result to sequencer FIFO
	output reg res_valid_ff,
	output reg [`ADCSQ_DATA_W-1:0] res_data_ff,
	output reg [3:0] res_seq_ff
);
	reg [7:0] pri_ff;
	reg [2:0] avg_ff;
	reg [3:0] act_ff;
	reg [15:0] trig_sel_ff;
	reg [3:0] pend_ff;
	reg [3:0] hw_s1_ff;
	reg [3:0] hw_s2_ff;
	reg [3:0] hw_s3_ff;
	reg [3:0] init_pulse_ff;
	reg [6:0] conv_left_ff;
	reg [3:0] nxt_pend;
	reg [31:0] nxt_rdata;
	wire [3:0] grant;
	wire [3:0] sw_ok;
	wire [3:0] hw_rise;
	wire avg_valid;
	wire [`ADCSQ_DATA_W-1:0] avg_data;
	wire req = (read || write) && waitrequest_ff;
	wire wr_hit = write && waitrequest_ff;
	wire [6:0] seq_len = 7'h01 << avg_ff;

	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] state_ff;

	// Pin triggers pass two flops, then rising edge detect
	always @(posedge clk) begin
		if (reset) begin
			hw_s1_ff <= 4'h0;
			hw_s2_ff <= 4'h0;
			hw_s3_ff <= 4'h0;
		end else begin
			hw_s1_ff <= hw_trig;
			hw_s2_ff <= hw_s1_ff;
			hw_s3_ff <= hw_s2_ff;
		end
	end
	assign hw_rise = hw_s2_ff & ~hw_s3_ff;

	// Per-sequencer software trigger qualification
	genvar g;
	generate
		for (g = 0; g < `ADCSQ_NSEQ; g = g + 1) begin : g_seq
			assign sw_ok[g] = init_pulse_ff[g] && act_ff[g] &&
				trig_sel_ff[4*g +: 4] == `ADCSQ_TRIG_CPU;
		end
	endgenerate

	adcsq_arbiter u_arb (
		.pend(pend_ff),
		.codes(pri_ff),
		.grant(grant)
	);

	// Bus slave: one wait cycle, answer at second edge
	always @(posedge clk) begin
		if (reset) begin
			waitrequest_ff <= 1'b1;
			readdata_ff <= 32'h00000000;
			pri_ff <= `ADCSQ_PRI_RST;
			avg_ff <= `ADCSQ_AVG_RST;
			act_ff <= 4'h0;
			trig_sel_ff <= 16'h0000;
			init_pulse_ff <= 4'h0;
		end else begin
			init_pulse_ff <= 4'h0;
			waitrequest_ff <= ~req;
			if (req)
				readdata_ff <= nxt_rdata;
			if (wr_hit) begin
				case (address)
				`ADCSQ_OFS_PRI: begin
					pri_ff[1:0] <= writedata[`ADCSQ_PRI_S0 +: 2];
					pri_ff[3:2] <= writedata[`ADCSQ_PRI_S1 +: 2];
					pri_ff[5:4] <= writedata[`ADCSQ_PRI_S2 +: 2];
					pri_ff[7:6] <= writedata[`ADCSQ_PRI_S3 +: 2];
				end
				`ADCSQ_OFS_INIT: init_pulse_ff <= writedata[3:0];
				`ADCSQ_OFS_AVG: avg_ff <= writedata[`ADCSQ_AVG_MSB:`ADCSQ_AVG_LSB];
				`ADCSQ_OFS_ACT: act_ff <= writedata[3:0];
				`ADCSQ_OFS_TRIG: trig_sel_ff <= writedata[15:0];
				default: begin
				end
				endcase
			end
		end
	end

	always @* begin
		nxt_rdata = 32'h00000000;
		case (address)
		`ADCSQ_OFS_PRI: begin
			nxt_rdata[`ADCSQ_PRI_S0 +: 2] = pri_ff[1:0];
			nxt_rdata[`ADCSQ_PRI_S1 +: 2] = pri_ff[3:2];
			nxt_rdata[`ADCSQ_PRI_S2 +: 2] = pri_ff[5:4];
			nxt_rdata[`ADCSQ_PRI_S3 +: 2] = pri_ff[7:6];
		end
		`ADCSQ_OFS_AVG: nxt_rdata[`ADCSQ_AVG_MSB:`ADCSQ_AVG_LSB] = avg_ff;
		`ADCSQ_OFS_ACT: nxt_rdata[3:0] = act_ff;
		`ADCSQ_OFS_TRIG: nxt_rdata[15:0] = trig_sel_ff;
		`ADCSQ_OFS_STAT: nxt_rdata[8:0] = {conv_busy_ff, pend_ff, active_seq_ff};
		default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Pending triggers: new set wins over the clear by grant
	always @* begin
		nxt_pend = pend_ff;
		if (state_ff == ST_IDLE)
			nxt_pend = nxt_pend & ~grant;
		nxt_pend = nxt_pend | sw_ok | (hw_rise & act_ff);
	end

	// Sequencing of converter runs
	always @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			pend_ff <= 4'h0;
			active_seq_ff <= 4'h0;
			conv_start_ff <= 1'b0;
			conv_busy_ff <= 1'b0;
			conv_left_ff <= 7'h00;
			res_valid_ff <= 1'b0;
			res_data_ff <= 10'h000;
			res_seq_ff <= 4'h0;
		end else begin
			pend_ff <= nxt_pend;
			conv_start_ff <= 1'b0;
			res_valid_ff <= avg_valid;
			res_data_ff <= avg_data;
			res_seq_ff <= active_seq_ff;
			case (state_ff)
			ST_IDLE: begin
				if (|grant) begin
					active_seq_ff <= grant;
					conv_start_ff <= 1'b1;
					conv_busy_ff <= 1'b1;
					conv_left_ff <= seq_len;
					state_ff <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (conv_done) begin
					if (conv_left_ff == 7'h01)
						state_ff <= ST_DONE;
					else
						conv_start_ff <= 1'b1;
					conv_left_ff <= conv_left_ff - 7'h01;
				end
			end
			ST_DONE: begin
				conv_busy_ff <= 1'b0;
				state_ff <= ST_IDLE;
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	adcsq_averager u_avg (
		.clk(clk),
		.reset(reset),
		.avg_exp(avg_ff),
		.start(conv_start_ff && state_ff == ST_RUN && conv_left_ff == seq_len),
		.conv_valid(conv_done && state_ff == ST_RUN),
		.conv_data(conv_data),
		.res_valid_ff(avg_valid),
		.res_data_ff(avg_data)
	);
endmodule

// file: bench/adcsq_chk_assertions.sv
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_chk (
	// Clock and bus
	input wire clk,
	input wire reset,
	input wire [`ADCSQ_ADDR_W-1:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [31:0] readdata_ff,
	input wire waitrequest_ff,
	// Converter side
	input wire conv_done,
	input wire [3:0] active_seq_ff,
	input wire res_valid_ff,
	input wire [3:0] res_seq_ff,
	input wire conv_start_ff,
	input wire conv_busy_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [6:0] n_ff;
	logic [2:0] a_ff;
	wire rok = read && !waitrequest_ff;
	// Counts conversions per result and tracks the exponent
	always @(posedge clk) begin
		if (reset) begin
			n_ff <= 7'h00;
			a_ff <= 3'h0;
		end else begin
			if (write && !waitrequest_ff && address == `ADCSQ_OFS_AVG)
				a_ff <= writedata[2:0];
			n_ff <= res_valid_ff ? 7'h00 : n_ff + {6'h00, conv_done};
		end
	end
	sequence s_acc;
		(read || write) && waitrequest_ff;
	endsequence
	AST_WAIT: assert property (s_acc |=> !waitrequest_ff)
		else $error("no answer to access");
	AST_INIT_RD: assert property (rok && address == `ADCSQ_OFS_INIT |-> readdata_ff == 0)
		else $error("initiate read not zero");
	AST_PRI_RSV: assert property (rok && address == `ADCSQ_OFS_PRI |->
		(readdata_ff & 32'hFFFFCCCC) == 0)
		else $error("priority reserved bits set");
	AST_AVG_RD: assert property (rok && address == `ADCSQ_OFS_AVG |->
		readdata_ff == {29'h0, a_ff})
		else $error("averaging readback wrong");
	AST_ONE_RUN: assert property ($onehot0(active_seq_ff))
		else $error("several sequencers run");
	AST_RES_SEQ: assert property (res_valid_ff |-> $onehot(res_seq_ff))
		else $error("result sequencer not one-hot");
	AST_AVG_CNT: assert property (res_valid_ff |-> n_ff == (7'h01 << a_ff))
		else $error("wrong conversion count");
	AST_RES_LAT: assert property (res_valid_ff |-> $past(conv_done, 2))
		else $error("result not two after last conversion");
	AST_START_BUSY: assert property (conv_start_ff |-> conv_busy_ff)
		else $error("conversion started while not busy");
	AST_FREE_AT_RES: assert property (res_valid_ff |-> !conv_busy_ff)
		else $error("converter still busy at result");
endmodule
bind adcsq_top adcsq_chk u_chk (.clk, .reset, .address, .read, .write, .writedata,
	.readdata_ff, .waitrequest_ff, .conv_done, .active_seq_ff, .res_valid_ff, .res_seq_ff,
	.conv_start_ff, .conv_busy_ff);

// file: bench/testbench.sv
`timescale 1ns/100ps
`include "adcsq_map.vh"
module testbench;
	logic clk = 0, reset = 1, read = 0, write = 0, conv_done = 0;
	logic [9:0] address = 0, conv_data = 0, dv = 10'h011;
	logic [31:0] writedata = 0, rdat;
	logic [2:0] sh = 0;
	logic [3:0] hw = 0;
	wire [31:0] readdata_ff;
	wire waitrequest_ff, conv_start_ff, res_valid_ff;
	wire [3:0] res_seq_ff;
	wire [9:0] res_data_ff;
	int n_mismatch = 0, cmp_count = 0, s = 0, ex = 0;
	logic [3:0] qs[$];
	adcsq_top dut (.clk, .reset, .address, .read, .write, .writedata, .readdata_ff,
		.waitrequest_ff, .hw_trig(hw), .conv_done, .conv_data, .conv_start_ff,
		.active_seq_ff(), .conv_busy_ff(), .res_valid_ff, .res_data_ff, .res_seq_ff);
	initial forever #2.5 clk = ~clk;
	// Converter answers each start four cycles later
	always @(posedge clk) begin
		sh <= {sh[1:0], conv_start_ff};
		conv_done <= sh[2];
		conv_data <= dv;
		if (sh[2]) dv <= dv + 10'h00D;
	end
	always @(posedge clk) if (!reset) begin
		if (conv_done) s += conv_data;
		if (res_valid_ff === 1'b1) begin
			qs.push_back(res_seq_ff);
			chk("res_data", s >> ex, res_data_ff);
			s = 0;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge clk); while (waitrequest_ff !== 1'b0);
		rdat = readdata_ff;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task rd(input string n, input logic [9:0] a, input logic [31:0] e);
		acc(0, a, 0);
		chk(n, e, rdat);
	endtask
	task wres(input int n);
		for (int i = 0; i < 2000 && qs.size() < n; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk("results", n, qs.size());
	endtask
	task results;
		$display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 0;
		rd("pri_rst", `ADCSQ_OFS_PRI, 32'h3210);
		rd("avg_rst", `ADCSQ_OFS_AVG, 0);
		rd("init_rd", `ADCSQ_OFS_INIT, 0);
		rd("unmapped", 10'h3F0, 0);
		acc(1, `ADCSQ_OFS_ACT, 4'hF);
		acc(1, `ADCSQ_OFS_PRI, 32'hFFFF0123);
		rd("pri_map", `ADCSQ_OFS_PRI, 32'h0123);
		acc(1, `ADCSQ_OFS_INIT, 4'hF);
		wres(4);
		for (int i = 3; i >= 0; i--) chk("order", 1 << i, qs.pop_front());
		acc(1, `ADCSQ_OFS_ACT, 4'h1);
		acc(1, `ADCSQ_OFS_INIT, 4'hE);
		wres(0);
		acc(1, `ADCSQ_OFS_ACT, 4'hF);
		acc(1, `ADCSQ_OFS_TRIG, 32'h0500);
		acc(1, `ADCSQ_OFS_INIT, 4'h6);
		wres(1);
		chk("source", 4'h2, qs.pop_front());
		acc(1, `ADCSQ_OFS_TRIG, 0);
		ex = 2;
		acc(1, `ADCSQ_OFS_AVG, 2);
		acc(1, `ADCSQ_OFS_INIT, 4'h1);
		wres(1);
		qs.delete();
		ex = 6;
		acc(1, `ADCSQ_OFS_AVG, 32'hFFFFFFFE);
		rd("avg_rd", `ADCSQ_OFS_AVG, 6);
		acc(1, `ADCSQ_OFS_INIT, 4'h8);
		wres(1);
		// Sequencer 0 runs while two pin triggers and a software trigger queue up
		qs.delete();
		ex = 0;
		acc(1, `ADCSQ_OFS_AVG, 0);
		acc(1, `ADCSQ_OFS_INIT, 4'h1);
		hw <= 4'h6;
		acc(1, `ADCSQ_OFS_INIT, 4'h8);
		wres(4);
		chk("queued0", 4'h1, qs.pop_front());
		chk("queued1", 4'h8, qs.pop_front());
		chk("queued2", 4'h4, qs.pop_front());
		chk("queued3", 4'h2, qs.pop_front());
		hw <= 4'h0;
		results;
	end
	initial begin
		#100000;
		n_mismatch++;
		results;
	end
endmodule
